// >>> src/adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// register indices as printed, byte address is four times the index
`define ADCC_IDX_CONTROL     10'h0f3
`define ADCC_IDX_RESULT_HIGH 10'h0f4
`define ADCC_IDX_RESULT_LOW  10'h0f5
`define ADCC_IDX_IRQ_STATUS  10'h0f8
`define ADCC_IDX_IRQ_MASK    10'h0f9

// control register fields
`define ADCC_CTL_START_BIT   0
`define ADCC_CTL_CLK_LSB     1
`define ADCC_CTL_CLK_MSB     2
`define ADCC_CTL_EOC_BIT     3
`define ADCC_CTL_CH_LSB      4
`define ADCC_CTL_CH_MSB      6

// reset values
`define ADCC_CTL_RESET       8'h00
`define ADCC_MASK_RESET      8'h00

// conversion clock divide ratios
`define ADCC_DIV_16          5'h10
`define ADCC_DIV_8           5'h08
`define ADCC_DIV_4           5'h04
`define ADCC_DIV_1           5'h01

// interrupt status bit
`define ADCC_IRQ_EOC_BIT     0

// axi responses
`define ADCC_RESP_OKAY       2'h0
`define ADCC_RESP_SLVERR     2'h2

`endif

// >>> src/adcc_pkg.sv
package adcc_pkg;

    typedef enum logic [1:0] {
        ADCC_CLK_DIV16,
        ADCC_CLK_DIV8,
        ADCC_CLK_DIV4,
        ADCC_CLK_DIV1
    } adcc_clk_sel_e;

    typedef enum logic {
        ADCC_IDLE,
        ADCC_CONVERTING
    } adcc_state_e;

    typedef logic [2:0] adcc_channel_t;

endpackage

// >>> src/adcc_clkdiv.sv
`include "adcc_params.svh"

module adcc_clkdiv (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // control
    input  wire logic                  run,
    input  wire adcc_pkg::adcc_clk_sel_e sel,
    // conversion clock enable
    output logic                       tick
);

    logic [4:0] ratio;
    logic [4:0] cnt_ff;
    logic       tick_ff;

    always_comb begin
        unique case (sel)
            adcc_pkg::ADCC_CLK_DIV16: ratio = `ADCC_DIV_16;
            adcc_pkg::ADCC_CLK_DIV8:  ratio = `ADCC_DIV_8;
            adcc_pkg::ADCC_CLK_DIV4:  ratio = `ADCC_DIV_4;
            adcc_pkg::ADCC_CLK_DIV1:  ratio = `ADCC_DIV_1;
        endcase
    end

    // one tick every ratio cycles while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff  <= 5'h00;
            tick_ff <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_ff  <= 5'h00;
                tick_ff <= 1'b0;
            end else if (cnt_ff >= ratio - 5'h01) begin
                cnt_ff  <= 5'h00;
                tick_ff <= 1'b1;
            end else begin
                cnt_ff  <= cnt_ff + 5'h01;
                tick_ff <= 1'b0;
            end
        end
    end

    assign tick = tick_ff;

endmodule // adcc_clkdiv

// >>> src/adcc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`include "adcc_params.svh"

module adcc_top (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    // axi4-lite write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    // axi4-lite read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // analog converter side
    output logic [2:0]       analog_channel,
    output logic             conv_enable,
    output logic             conv_start,
    output logic             conv_clk_tick,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    // interrupt
    output logic             irq
);

    localparam logic [11:0] ADDR_CONTROL = {`ADCC_IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_RES_HI  = {`ADCC_IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] ADDR_RES_LO  = {`ADCC_IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] ADDR_STATUS  = {`ADCC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_MASK    = {`ADCC_IDX_IRQ_MASK, 2'b00};

    ////////////////////////////////////////////////////////////////////////////
    // write channel
    logic                     awready_ff;
    logic                     wready_ff;
    logic                     aw_held_ff;
    logic                     w_held_ff;
    logic [11:0]              waddr_ff;
    logic [7:0]               wbyte_ff;
    logic                     wlane_ff;
    logic                     bvalid_ff;
    logic [1:0]               bresp_ff;
    logic                     do_write;

    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            waddr_ff   <= 12'h000;
        end else if (ce) begin
            if (awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                waddr_ff   <= awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wbyte_ff  <= 8'h00;
            wlane_ff  <= 1'b0;
        end else if (ce) begin
            if (wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                wbyte_ff  <= wdata[7:0];
                wlane_ff  <= wstrb[0];
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // ready only while nothing of that kind is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else if (ce) begin
            awready_ff <= !(aw_held_ff || (awvalid && awready_ff)) || do_write;
            wready_ff  <= !(w_held_ff || (wvalid && wready_ff)) || do_write;
            if (do_write) begin
                awready_ff <= 1'b0;
                wready_ff  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `ADCC_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (waddr_ff == ADDR_CONTROL || waddr_ff == ADDR_MASK)
                             ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register and sequencer
    logic                     wr_ctl;
    logic                     wr_mask;
    logic [2:0]               chan_ff;
    logic [1:0]               clk_sel_ff;
    logic                     enable_ff;
    logic                     eoc_ff;
    logic                     start_ff;
    adcc_pkg::adcc_state_e    state_ff;
    logic [15:0]              result_ff;
    logic                     done_meta_ff;
    logic                     done_sync_ff;
    logic                     done_prev_ff;
    logic                     done_event;
    logic                     tick;

    assign wr_ctl  = do_write && wlane_ff && waddr_ff == ADDR_CONTROL;
    assign wr_mask = do_write && wlane_ff && waddr_ff == ADDR_MASK;

    // control fields; bit 3 is not taken from the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_ff    <= 3'(`ADCC_CTL_RESET >> `ADCC_CTL_CH_LSB);
            clk_sel_ff <= 2'h0;
            enable_ff  <= 1'b0;
        end else if (ce && wr_ctl) begin
            chan_ff    <= wbyte_ff[`ADCC_CTL_CH_MSB:`ADCC_CTL_CH_LSB];
            clk_sel_ff <= wbyte_ff[`ADCC_CTL_CLK_MSB:`ADCC_CTL_CLK_LSB];
            enable_ff  <= wbyte_ff[`ADCC_CTL_START_BIT];
        end
    end

    // converter done arrives from the analog side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_meta_ff <= 1'b0;
            done_sync_ff <= 1'b0;
            done_prev_ff <= 1'b0;
        end else if (ce) begin
            done_meta_ff <= conv_done;
            done_sync_ff <= done_meta_ff;
            done_prev_ff <= done_sync_ff;
        end
    end

    assign done_event = done_sync_ff && !done_prev_ff && state_ff == adcc_pkg::ADCC_CONVERTING;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= adcc_pkg::ADCC_IDLE;
            start_ff <= 1'b0;
        end else if (ce) begin
            start_ff <= wr_ctl && wbyte_ff[`ADCC_CTL_START_BIT];
            if (wr_ctl && wbyte_ff[`ADCC_CTL_START_BIT]) begin
                state_ff <= adcc_pkg::ADCC_CONVERTING;
            end else if (wr_ctl || done_event) begin
                state_ff <= adcc_pkg::ADCC_IDLE;
            end
        end
    end

    // start clears, completion sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc_ff    <= 1'b0;
            result_ff <= 16'h0000;
        end else if (ce) begin
            if (wr_ctl && wbyte_ff[`ADCC_CTL_START_BIT]) begin
                eoc_ff <= 1'b0;
            end else if (done_event) begin
                eoc_ff    <= 1'b1;
                result_ff <= conv_result;
            end
        end
    end

    adcc_clkdiv u_clkdiv (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .run     (state_ff == adcc_pkg::ADCC_CONVERTING),
        .sel     (adcc_pkg::adcc_clk_sel_e'(clk_sel_ff)),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt
    logic [7:0]               irq_sts_ff;
    logic [7:0]               irq_mask_ff;
    logic                     irq_ff;
    logic                     rd_sts;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_ff <= `ADCC_MASK_RESET;
        end else if (ce && wr_mask) begin
            irq_mask_ff <= wbyte_ff;
        end
    end

    // completion wins over read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_sts_ff <= 8'h00;
        end else if (ce) begin
            irq_sts_ff <= (rd_sts ? 8'h00 : irq_sts_ff)
                          | {7'h00, done_event};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= |(irq_sts_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    logic                     arready_ff;
    logic                     rvalid_ff;
    logic [31:0]              rdata_ff;
    logic [1:0]               rresp_ff;
    logic                     rd_take;
    logic [7:0]               rd_byte;
    logic                     rd_hit;

    assign rd_take = arvalid && arready_ff;
    assign rd_sts  = rd_take && araddr == ADDR_STATUS;

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (araddr)
            ADDR_CONTROL: rd_byte = {1'b0, chan_ff, eoc_ff, clk_sel_ff, enable_ff};
            ADDR_RES_HI:  rd_byte = result_ff[15:8];
            ADDR_RES_LO:  rd_byte = result_ff[7:0];
            ADDR_STATUS:  rd_byte = irq_sts_ff;
            ADDR_MASK:    rd_byte = irq_mask_ff;
            default:      rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `ADCC_RESP_OKAY;
        end else if (ce) begin
            if (rd_take) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= {24'h000000, rd_byte};
                rresp_ff   <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (rvalid_ff) begin
                if (rready) begin
                    rvalid_ff <= 1'b0;
                end
            end else begin
                arready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter outputs
    logic                     tick_out_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_out_ff   <= 1'b0;
        end else if (ce) begin
            tick_out_ff   <= tick;
        end
    end

    assign awready        = awready_ff;
    assign wready         = wready_ff;
    assign bvalid         = bvalid_ff;
    assign bresp          = bresp_ff;
    assign arready        = arready_ff;
    assign rvalid         = rvalid_ff;
    assign rdata          = rdata_ff;
    assign rresp          = rresp_ff;
    // channel and enable leave the control flops directly, in step with start
    assign analog_channel = chan_ff;
    assign conv_enable    = enable_ff;
    assign conv_start     = start_ff;
    assign conv_clk_tick  = tick_out_ff;
    assign irq            = irq_ff;

endmodule // adcc_top

// >>> verif/adcc_checker.sv
module adcc_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // converter side
    input wire logic [2:0]  analog_channel,
    input wire logic        conv_enable,
    input wire logic        conv_start,
    input wire logic        conv_clk_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wr_answer;
        ##[1:2] bvalid;
    endsequence
    wr_answer_a: assert property (wr_taken |-> wr_answer)
        else $error("write response late");
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    start_cause_a: assert property (conv_start |-> conv_enable && (bvalid || $past(bvalid)))
        else $error("start without control write");
    chan_change_a: assert property ($changed(analog_channel) |-> bvalid || $past(bvalid))
        else $error("channel changed without write");
    enable_change_a: assert property ($changed(conv_enable) |-> bvalid || $past(bvalid))
        else $error("enable changed without write");
    tick_idle_a: assert property (!conv_enable [*3] |-> !conv_clk_tick)
        else $error("conversion clock while disabled");
endmodule // adcc_checker

bind adcc_top adcc_checker u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .analog_channel,
    .conv_enable, .conv_start, .conv_clk_tick);

// >>> verif/adcc_conv_model.sv
module adcc_conv_model (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // control from block, conversion length from the bench
    input wire logic [2:0]  analog_channel,
    input wire logic        conv_enable,
    input wire logic        conv_start,
    input wire logic        conv_clk_tick,
    input wire logic [7:0]  ticks,
    // answer
    output logic            conv_done,
    output logic [15:0]     conv_result
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_ff;
    logic       busy_ff;
    logic       en_ff;
    logic [2:0] hold_ff;
    always_ff @(posedge aclk) begin
        en_ff <= conv_enable;
        if (!aresetn) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
            hold_ff <= 3'h0;
            conv_done <= 1'b0;
            conv_result <= 16'h0000;
        end else if (conv_start) begin
            busy_ff <= 1'b1;
            cnt_ff <= 8'h00;
            conv_done <= 1'b0;
        end else if (busy_ff && en_ff && !conv_enable) begin
            busy_ff <= 1'b0;
        end else if (busy_ff && conv_clk_tick) begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff + 8'h01 >= ticks) begin
                busy_ff <= 1'b0;
                conv_done <= 1'b1;
                hold_ff <= 3'h0;
                conv_result <= {5'h15, analog_channel, 8'hc3};
            end
        end else if (conv_done) begin
            hold_ff <= hold_ff + 3'h1;
            // hold window over: lines no longer carry the result
            if (hold_ff == 3'h5) begin
                conv_done <= 1'b0;
                conv_result <= ~conv_result;
            end
        end
    end
endmodule // adcc_conv_model

// >>> verif/adcc_top_tb.sv
`include "adcc_params.svh"

module adcc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_CTL  = {`ADCC_IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_HIGH = {`ADCC_IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] A_LOW  = {`ADCC_IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] A_STAT = {`ADCC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {`ADCC_IDX_IRQ_MASK, 2'b00};
    localparam logic [1:0]  OK     = `ADCC_RESP_OKAY;
    localparam logic [1:0]  ERR    = `ADCC_RESP_SLVERR;
    logic [4:0]  divs [4] = '{`ADCC_DIV_16, `ADCC_DIV_8, `ADCC_DIV_4, `ADCC_DIV_1};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [7:0]  ticks = 8'h03;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        conv_enable, conv_start, conv_clk_tick, conv_done;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  analog_channel;
    logic [15:0] conv_result;
    int          fails = 0;
    int          checked = 0;
    ////////////////////////////////////////
    adcc_top dut (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .analog_channel,
        .conv_enable, .conv_start, .conv_clk_tick, .conv_done, .conv_result, .irq);
    adcc_conv_model conv (.aclk, .aresetn, .analog_channel, .conv_enable, .conv_start,
        .conv_clk_tick, .ticks, .conv_done, .conv_result);
    ////////////////////////////////////////
    task automatic print_verdict;
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrc(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin @(posedge aclk); n++; end while (conv_done !== 1'b1 && n < 400);
        if (conv_done !== 1'b1)
            fails++;
        repeat (6) @(posedge aclk);
    endtask
    ////////////////////////////////////////
    initial begin
        forever #25 aclk = ~aclk;
    end
    initial begin
        #500000;
        fails++;
        print_verdict;
    end
    initial begin
        int n;
        int m;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(A_CTL, 32'h0, OK);
        rdc(A_MASK, 32'h0, OK);
        for (int c = 0; c < 8; c++) begin
            wrc(A_CTL, 8'(c << 4), 4'h1, OK);
            rdc(A_CTL, 32'(c << 4), OK);
            chk(32'(analog_channel), 32'(c));
        end
        for (int s = 0; s < 4; s++) begin
            wrc(A_CTL, 8'h31 | 8'(s << 1), 4'h1, OK);
            n = 0;
            do begin @(posedge aclk); n++; end while (conv_clk_tick !== 1'b1 && n < 100);
            m = 0;
            do begin @(posedge aclk); m++; end while (conv_clk_tick !== 1'b1 && m < 100);
            chk(32'(m), 32'(divs[s]));
            wait_done;
            rdc(A_CTL, 32'h39 | 32'(s << 1), OK);
            rdc(A_HIGH, 32'hab, OK);
            rdc(A_LOW, 32'hc3, OK);
        end
        wrc(A_CTL, 8'h00, 4'h1, OK);
        rdc(A_CTL, 32'h08, OK);
        wrc(A_CTL, 8'h01, 4'h1, OK);
        rdc(A_CTL, 32'h01, OK);
        wrc(A_CTL, 8'h08, 4'h1, OK);
        repeat (150) @(posedge aclk);
        rdc(A_CTL, 32'h00, OK);
        ticks <= 8'h01;
        wrc(A_CTL, 8'h07, 4'h1, OK);
        wait_done;
        chk(32'(irq), 32'h0);
        wrc(A_MASK, 8'h01, 4'h1, OK);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        rdc(A_STAT, 32'h1, OK);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rdc(A_STAT, 32'h0, OK);
        wrc(A_HIGH, 8'h55, 4'h1, ERR);
        wrc(12'h000, 8'h01, 4'h1, ERR);
        rdc(12'h000, 32'h0, ERR);
        wrc(A_CTL, 8'h70, 4'h0, OK);
        rdc(A_CTL, 32'h0f, OK);
        print_verdict;
    end
endmodule // adcc_top_tb
